// file: rtl/sleep_power_reset_control.sv
// Sleep, power-reduction and reset-source control behind an APB slave
`timescale 1ns/1ps
module sleep_power_reset_control #(
    parameter int TOUT_CYCLES = 65536
) (
    // Clock, reset, enable
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 ce_i,
    // APB slave
    input  wire logic                 psel_i,
    input  wire logic                 penable_i,
    input  wire logic                 pwrite_i,
    input  wire logic [11:0]          paddr_i,
    input  wire logic [31:0]          pwdata_i,
    output logic      [31:0]          prdata_o,
    output logic                      pready_o,
    output logic                      pslverr_o,
    // Reset sources and fuses
    input  wire spr_pkg::rst_src_t    rst_src_i,
    input  wire logic                 reset_pin_disable_fuse_i,
    input  wire logic                 brownout_enable_fuse_i,
    input  wire logic                 wdt_system_mode_i,
    // Core and peripheral hooks
    input  wire logic                 sleep_instr_i,
    input  wire logic                 wake_i,
    input  wire logic                 timer2_async_select_i,
    output logic                      port_reset_o,
    output logic                      core_reset_o,
    output logic                      sleeping_o,
    output logic [2:0]                sleep_state_o,
    output logic                      brownout_detector_off_o,
    output logic                      core_clk_en_o,
    output logic [7:0]                periph_clk_stop_o,
    output logic                      comparator_mux_deny_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset sources: synchronise, filter and combine

    logic [2:0] pin_sync_r, por_sync_r, bod_sync_r;
    logic       pin_low_r, por_on_r, bod_on_r, wdt_d_r;
    logic [2:0] bod_cnt_r;
    logic       any_src;
    logic [16:0] tout_cnt_r;
    logic       int_rst_r;
    logic       soft_rst;

    always_ff @(posedge clk_sys_i) begin
        if (ce_i) begin
            pin_sync_r <= {pin_sync_r[1:0], ~rst_src_i.pin_n};
            por_sync_r <= {por_sync_r[1:0], rst_src_i.por};
            bod_sync_r <= {bod_sync_r[1:0], rst_src_i.brownout_detector};
            if (pin_sync_r[2] == pin_sync_r[1])
                pin_low_r <= pin_sync_r[2];
            if (por_sync_r[2] == por_sync_r[1])
                por_on_r <= por_sync_r[2];
            wdt_d_r <= rst_src_i.wdt & wdt_system_mode_i;
        end
    end

    // Drops shorter than the filter count never reach reset
    always_ff @(posedge clk_sys_i) begin
        if (ce_i) begin
            if (!(bod_sync_r[2] && bod_sync_r[1] && brownout_enable_fuse_i)) begin
                bod_cnt_r <= 3'h0;
                bod_on_r  <= 1'b0;
            end else if (bod_cnt_r == spr_pkg::BOD_FILT) begin // see R22
                bod_on_r <= 1'b1;
            end else begin
                bod_cnt_r <= bod_cnt_r + 3'h1;
            end
        end
    end

    // Pin and power-on act without clock; brown-out after its filter
    assign any_src = rst_src_i.por
                   | (~rst_src_i.pin_n & ~reset_pin_disable_fuse_i)   // see R19, R20
                   | (rst_src_i.wdt & wdt_system_mode_i)
                   | bod_on_r;                                        // see R18, R21, R22

    // Asynchronous port reset, no clock needed
    always_ff @(posedge clk_sys_i or posedge any_src) begin
        if (any_src)
            port_reset_o <= 1'b1; // see R16
        else if (ce_i)
            port_reset_o <= int_rst_r;
    end

    // Delay counter restarts while any source holds and after watchdog pulse end
    always_ff @(posedge clk_sys_i or posedge any_src) begin
        if (any_src) begin
            tout_cnt_r <= 17'h0;
            int_rst_r  <= 1'b1;
        end else if (!rst_n_i) begin
            tout_cnt_r <= 17'h0;
            int_rst_r  <= 1'b1;
        end else if (ce_i) begin
            if (wdt_d_r) begin
                tout_cnt_r <= 17'h0; // see R23
                int_rst_r  <= 1'b1;
            end else if (int_rst_r) begin
                if (tout_cnt_r >= 17'(TOUT_CYCLES - 1))
                    int_rst_r <= 1'b0; // see R17, R19, R21
                else
                    tout_cnt_r <= tout_cnt_r + 17'h1;
            end
        end
    end

    assign soft_rst = int_rst_r | ~rst_n_i;

    always_ff @(posedge clk_sys_i) begin
        if (ce_i)
            core_reset_o <= int_rst_r; // see R15
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0] sleep_ctl_r, core_ctl_r, prr_r;
    logic [2:0] unlock_cnt_r, bso_cnt_r;
    logic       wr_en, rd_en;
    logic [7:0] wbyte;

    // Writes land at the edge where the master samples pready high
    assign wr_en = psel_i & penable_i & pwrite_i & pready_o;
    assign rd_en = psel_i & penable_i & ~pwrite_i & ~pready_o;
    assign wbyte = pwdata_i[7:0];

    always_ff @(posedge clk_sys_i) begin
        if (soft_rst) begin
            sleep_ctl_r <= spr_pkg::RST_VAL;
        end else if (ce_i && wr_en && paddr_i == spr_pkg::SLEEP_OFF) begin
            sleep_ctl_r <= wbyte & spr_pkg::SLEEP_MASK; // see R1, R26
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (soft_rst) begin
            prr_r <= spr_pkg::RST_VAL; // see R9
        end else if (ce_i && wr_en && paddr_i == spr_pkg::PRR_OFF) begin
            prr_r <= wbyte & spr_pkg::PRR_MASK; // see R9, R26
        end
    end

    // Unlock window and self-clearing sleep-off bit
    always_ff @(posedge clk_sys_i) begin
        if (soft_rst) begin
            core_ctl_r   <= spr_pkg::RST_VAL;
            unlock_cnt_r <= 3'h0;
            bso_cnt_r    <= 3'h0;
        end else if (ce_i) begin
            if (unlock_cnt_r != 3'h0)
                unlock_cnt_r <= unlock_cnt_r - 3'h1;
            if (core_ctl_r[spr_pkg::BSO_BIT]) begin
                if (bso_cnt_r == spr_pkg::BSO_DELAY) begin
                    core_ctl_r[spr_pkg::BSO_BIT] <= 1'b0; // see R7
                    bso_cnt_r <= 3'h0;
                end else begin
                    bso_cnt_r <= bso_cnt_r + 3'h1;
                end
            end
            if (wr_en && paddr_i == spr_pkg::CORE_OFF) begin
                core_ctl_r[spr_pkg::BSU_BIT] <= wbyte[spr_pkg::BSU_BIT];
                if (wbyte[spr_pkg::BSO_BIT] && wbyte[spr_pkg::BSU_BIT]) begin
                    unlock_cnt_r <= spr_pkg::UNLOCK_WIN; // see R5
                end else if (wbyte[spr_pkg::BSO_BIT] && unlock_cnt_r != 3'h0) begin
                    core_ctl_r[spr_pkg::BSO_BIT] <= 1'b1; // see R5, R8
                    bso_cnt_r    <= 3'h0;
                    unlock_cnt_r <= 3'h0;
                end
            end
        end
    end

    // One-wait-state APB; unmapped offsets read zero and flag an error
    always_ff @(posedge clk_sys_i) begin
        if (soft_rst) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0;
        end else if (ce_i) begin
            pready_o  <= psel_i & penable_i & ~pready_o;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0;
            if (psel_i && penable_i && !pready_o) begin
                unique case (paddr_i)
                    spr_pkg::SLEEP_OFF:  prdata_o <= {24'h0, sleep_ctl_r};
                    spr_pkg::CORE_OFF:   prdata_o <= {24'h0, core_ctl_r};
                    spr_pkg::PRR_OFF:    prdata_o <= {24'h0, prr_r};
                    spr_pkg::STATUS_OFF: prdata_o <= {29'h0, brownout_detector_off_o, sleeping_o, por_on_r};
                    default:             pslverr_o <= 1'b1;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sleep control

    spr_pkg::pstate_t state_r;
    logic [2:0] wake_cnt_r;
    logic       bso_active;
    logic       wake_fast;

    // Sleep-off becomes active once its third cycle is reached
    assign bso_active = core_ctl_r[spr_pkg::BSO_BIT] && bso_cnt_r == spr_pkg::BSO_DELAY; // see R6
    assign wake_fast  = sleep_state_o == spr_pkg::SM_STANDBY || sleep_state_o == spr_pkg::SM_EXT_STBY;

    always_ff @(posedge clk_sys_i) begin
        if (soft_rst) begin
            state_r                 <= spr_pkg::RUN;
            wake_cnt_r              <= 3'h0;
            sleeping_o              <= 1'b0;
            sleep_state_o           <= 3'h0;
            brownout_detector_off_o <= 1'b0;
            core_clk_en_o           <= 1'b0;
        end else if (ce_i) begin
            unique case (state_r)
                spr_pkg::RUN: begin
                    core_clk_en_o <= 1'b1;
                    // Without the arm bit a sleep instruction does nothing
                    if (sleep_instr_i && sleep_ctl_r[spr_pkg::ARM_BIT]) begin // see R3, R25
                        state_r                 <= spr_pkg::SLEEPING;
                        sleeping_o              <= 1'b1;
                        sleep_state_o           <= sleep_ctl_r[3:1]; // see R2
                        brownout_detector_off_o <= bso_active;       // see R6
                        core_clk_en_o           <= 1'b0;
                    end
                end
                spr_pkg::SLEEPING: begin
                    if (wake_i) begin
                        state_r                 <= spr_pkg::WAKING;
                        brownout_detector_off_o <= 1'b0;
                        wake_cnt_r              <= 3'h1;
                    end
                end
                spr_pkg::WAKING: begin
                    // Other modes wait until the wake counter reaches 7 for oscillator restart
                    if ((wake_fast && wake_cnt_r == spr_pkg::WAKE_CYCLES - 3'h1) ||
                        (!wake_fast && wake_cnt_r == 3'h7)) begin // see R24
                        state_r       <= spr_pkg::RUN;
                        sleeping_o    <= 1'b0;
                        core_clk_en_o <= 1'b1;
                    end else begin
                        wake_cnt_r <= wake_cnt_r + 3'h1;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Peripheral clock gates

    always_ff @(posedge clk_sys_i) begin
        if (soft_rst) begin
            periph_clk_stop_o     <= 8'h00;
            comparator_mux_deny_o <= 1'b0;
        end else if (ce_i) begin
            periph_clk_stop_o[spr_pkg::G_TWI]  <= prr_r[spr_pkg::G_TWI];  // see R10
            periph_clk_stop_o[spr_pkg::G_SPI]  <= prr_r[spr_pkg::G_SPI];  // see R10
            periph_clk_stop_o[spr_pkg::G_UART] <= prr_r[spr_pkg::G_UART]; // see R10
            periph_clk_stop_o[spr_pkg::G_T2]   <= prr_r[spr_pkg::G_T2] & ~timer2_async_select_i; // see R11
            periph_clk_stop_o[spr_pkg::G_T0]   <= prr_r[spr_pkg::G_T0];   // see R12
            periph_clk_stop_o[spr_pkg::G_T1]   <= prr_r[spr_pkg::G_T1];   // see R12
            periph_clk_stop_o[4]               <= 1'b0;
            periph_clk_stop_o[spr_pkg::G_ADC]  <= prr_r[spr_pkg::G_ADC];
            comparator_mux_deny_o              <= prr_r[spr_pkg::G_ADC];  // see R13
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking chk_cb @(posedge clk_sys_i);
    endclocking

        sleep_hi_zero_a: assert property (disable iff (!rst_n_i) sleep_ctl_r[7:4] == 4'h0) // see R1
            else $error("sleep control upper bits not zero");
        prr_rsv_zero_a: assert property (disable iff (!rst_n_i) prr_r[4] == 1'b0) // see R9
            else $error("reserved power reduction bit set");
        bso_selfclear_a: assert property (disable iff (!rst_n_i)
            ($rose(core_ctl_r[spr_pkg::BSO_BIT]) && ce_i) |-> ##[1:8] !core_ctl_r[spr_pkg::BSO_BIT]) // see R7
            else $error("sleep-off bit not self-cleared");
        bso_locked_a: assert property (disable iff (!rst_n_i)
            $rose(core_ctl_r[spr_pkg::BSO_BIT]) |-> $past(unlock_cnt_r) != 3'h0) // see R5
            else $error("sleep-off set without unlock");
        no_arm_sleep_a: assert property (disable iff (!rst_n_i || int_rst_r)
            (state_r == spr_pkg::RUN && !sleep_ctl_r[spr_pkg::ARM_BIT] && ce_i) |=> state_r == spr_pkg::RUN) // see R25
            else $error("sleep entered without arm bit");
        fast_wake_a: assert property (disable iff (!rst_n_i || int_rst_r)
            (state_r == spr_pkg::SLEEPING && wake_i && wake_fast && ce_i) ##1 ce_i[*5] |=> !sleeping_o) // see R24
            else $error("standby wake too slow");
        t2_async_a: assert property (disable iff (!rst_n_i)
            (ce_i && timer2_async_select_i) |=> !periph_clk_stop_o[spr_pkg::G_T2]) // see R11
            else $error("timer 2 halted in async mode");
        por_reset_a: assert property (rst_src_i.por |-> ##[0:1] int_rst_r) // see R21
            else $error("power-on did not assert reset");

endmodule

// file: rtl/spr_pkg.sv
// Constants and types for the sleep, power-reduction and reset control block
//
// Overview of operation
// R1: Sleep control bits 7..4 always read zero.
// R2: Bits 3..1 select idle, noise-reduction, power-down, power-save, standby, extended standby.
// R3: Sleep instruction enters sleep only while sleep arm bit 0 is one.
// R4: Software sets sleep arm just before sleep and clears it after waking.
// R5: Sleep-off set needs both bits one, then sleep-off alone within four cycles.
// R6: Sleep-off active three cycles after set; sleep then turns detector off.
// R7: Hardware clears the sleep-off bit three cycles after it was set; the code clears it four cycles after.
// R8: Core control bit 6 is sleep-off, bit 5 unlock; set only via unlock.
// R9: Power reduction at 0x64 resets to zero; bit 4 reads zero.
// R10: Bits 7, 2, 1 stop two-wire, serial peripheral, serial port clocks.
// R11: Bit 6 halts timer 2 only when async select is zero.
// R12: Bits 5 and 3 halt timer 0 and timer 1, resuming unchanged.
// R13: Converter disabled before bit 0 set; comparator loses the converter mux.
// R14: Software reinitialises serial units after ungating; no spi gate while debugging.
// R15: During reset all registers take initial values; then start at reset vector.
// R16: Port pins reset at once, asynchronously, when any source asserts.
// R17: After all sources release, delay counter stretches reset by fuse-chosen time; the code uses the fixed TOUT_CYCLES parameter.
// R18: Reset is OR of power-on, pin, watchdog system reset, enabled brown-out.
// R19: Long pin low resets without clock; delay counter runs after release.
// R20: A fuse disables the reset pin function.
// R21: Power-on low reasserts reset at once; rise starts the delay counter.
// R22: Enabled brown-out drop resets at once; short drops are filtered.
// R23: Watchdog gives a one-cycle pulse; delay starts at its falling edge.
// R24: Standby and extended standby wake in six cycles.
// R25: Sleep with arm bit zero is a no-operation.
// R26: Writes to reserved bits are ignored and they stay zero.
package spr_pkg;
    localparam logic [11:0] PRR_OFF       = 12'h064;
    localparam logic [11:0] SLEEP_OFF     = 12'h053;
    localparam logic [11:0] CORE_OFF      = 12'h055;
    localparam logic [11:0] STATUS_OFF    = 12'h100;
    localparam logic [7:0]  SLEEP_MASK    = 8'h0F;
    localparam logic [7:0]  PRR_MASK      = 8'hEF;
    localparam logic [7:0]  RST_VAL       = 8'h00;
    localparam int          ARM_BIT       = 0;
    localparam int          BSO_BIT       = 6;
    localparam int          BSU_BIT       = 5;
    localparam int          G_ADC = 0, G_UART = 1, G_SPI = 2, G_T1 = 3, G_T0 = 5, G_T2 = 6, G_TWI = 7;
    localparam logic [2:0]  UNLOCK_WIN    = 3'h4;
    localparam logic [2:0]  BSO_DELAY     = 3'h3;
    localparam logic [2:0]  WAKE_CYCLES   = 3'h6;
    localparam logic [2:0]  BOD_FILT      = 3'h4;
    localparam logic [2:0]  SM_STANDBY    = 3'h6;
    localparam logic [2:0]  SM_EXT_STBY   = 3'h7;
    localparam int          CLK_MHZ       = 50;

    typedef enum logic [2:0] {
        SM_IDLE, SM_NOISE, SM_PDOWN, SM_PSAVE, SM_RSV4, SM_RSV5, SM_STBY, SM_XSTBY
    } sleep_sel_t;

    typedef enum {
        RUN, SLEEPING, WAKING
    } pstate_t;

    typedef struct packed {
        logic por;
        logic pin_n;
        logic wdt;
        logic brownout_detector;
    } rst_src_t;
endpackage

// file: sim/tb.sv
// Self-checking bench for the sleep, power-reduction and reset control block
`timescale 1ns/1ps
module tb;
    localparam int TOUT = 16;
    logic                clk_sys_i = 1'b0;
    logic                rst_n_i   = 1'b0;
    logic                psel_i    = 1'b0;
    logic                penable_i = 1'b0;
    logic                pwrite_i  = 1'b0;
    logic [11:0]         paddr_i   = 12'h000;
    logic [31:0]         pwdata_i  = 32'h0;
    logic [31:0]         prdata_o;
    logic                pready_o;
    logic                pslverr_o;
    spr_pkg::rst_src_t   rst_src_i = 4'h4;
    logic                reset_pin_disable_fuse_i = 1'b0;
    logic                brownout_enable_fuse_i   = 1'b1;
    logic                wdt_system_mode_i        = 1'b1;
    logic                sleep_instr_i = 1'b0;
    logic                wake_i        = 1'b0;
    logic                timer2_async_select_i = 1'b0;
    logic                port_reset_o, core_reset_o, sleeping_o, brownout_detector_off_o;
    logic                core_clk_en_o, comparator_mux_deny_o;
    logic [2:0]          sleep_state_o;
    logic [7:0]          periph_clk_stop_o;
    logic [31:0]         rdv;
    logic                erv;
    int                  error_cnt = 0;
    int                  comparisons = 0;
    int                  cyc = 0;
    logic [2:0]          md [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};

    sleep_power_reset_control #(.TOUT_CYCLES(TOUT)) u_sleep_power_reset_control (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .rst_src_i(rst_src_i), .reset_pin_disable_fuse_i(reset_pin_disable_fuse_i),
        .brownout_enable_fuse_i(brownout_enable_fuse_i), .wdt_system_mode_i(wdt_system_mode_i),
        .sleep_instr_i(sleep_instr_i), .wake_i(wake_i), .timer2_async_select_i(timer2_async_select_i),
        .port_reset_o(port_reset_o), .core_reset_o(core_reset_o), .sleeping_o(sleeping_o),
        .sleep_state_o(sleep_state_o), .brownout_detector_off_o(brownout_detector_off_o),
        .core_clk_en_o(core_clk_en_o), .periph_clk_stop_o(periph_clk_stop_o),
        .comparator_mux_deny_o(comparator_mux_deny_o));

    initial begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("comparisons %0d, errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chk_in(input string nm, input int lo, input int hi, input int got);
        comparisons++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Starts in the time step of an edge; request held until pready is sampled
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= wr;
        paddr_i   <= a;
        pwdata_i  <= wd;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        rdv = prdata_o;
        erv = pslverr_o;
    endtask

    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk_sys_i);
        apb(wr, a, wd);
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic do_sleep(input logic [2:0] m, input logic arm, input int wk, input logic bdo);
        int n;
        n = 0;
        sleep_instr_i <= 1'b1;
        @(posedge clk_sys_i);
        sleep_instr_i <= 1'b0;
        #1;
        chk("sleeping", 32'(arm), 32'(sleeping_o));
        if (arm) begin
            chk("state", 32'(m), 32'(sleep_state_o));
            chk("bod_off", 32'(bdo), 32'(brownout_detector_off_o));
            @(posedge clk_sys_i);
            wake_i <= 1'b1;
            do begin
                @(posedge clk_sys_i);
                wake_i <= 1'b0;
                #1;
                n++;
            end while (sleeping_o !== 1'b0 && n < 40);
            chk_in("wake", wk, wk + 1, n);
        end
        xfer(1'b1, spr_pkg::SLEEP_OFF, {28'h0, m, 1'b0});
    endtask

    task automatic rst_case(input logic [3:0] src, input int hold, input logic exp, input logic asy);
        int n;
        n = 0;
        xfer(1'b1, spr_pkg::PRR_OFF, 32'h21);
        @(posedge clk_sys_i);
        rst_src_i <= src;
        #1;
        if (asy) chk("port_async", 32'(exp), 32'(port_reset_o));
        repeat (hold) @(posedge clk_sys_i);
        rst_src_i <= 4'h4;
        #1;
        chk("core_rst", 32'(exp), 32'(core_reset_o));
        if (exp) begin
            while (core_reset_o === 1'b1 && n < 60) begin
                @(posedge clk_sys_i);
                #1;
                n++;
            end
            chk_in("delay", TOUT, TOUT + 6, n);
            xfer(1'b0, spr_pkg::PRR_OFF, 32'h0);
            chk("prr_reinit", 32'h0, rdv);
        end else begin
            repeat (10) @(posedge clk_sys_i);
            #1;
            chk("no_rst", 32'h0, 32'(core_reset_o));
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end

    initial begin
        repeat (3) @(posedge clk_sys_i);
        #1;
        chk("rst_port", 32'h1, 32'(port_reset_o));
        chk("rst_core", 32'h1, 32'(core_reset_o));
        rst_n_i <= 1'b1;
        while (core_reset_o !== 1'b0 && cyc < 200) @(posedge clk_sys_i);
        xfer(1'b0, spr_pkg::PRR_OFF, 32'h0);
        chk("prr_reset", 32'h0, rdv);
        xfer(1'b1, spr_pkg::PRR_OFF, 32'hFF);
        xfer(1'b0, spr_pkg::PRR_OFF, 32'h0);
        chk("prr_rw", 32'hEF, rdv);
        chk("gates", 32'hEF, 32'(periph_clk_stop_o));
        chk("cmp_deny", 32'h1, 32'(comparator_mux_deny_o));
        timer2_async_select_i <= 1'b1;
        @(posedge clk_sys_i);
        @(posedge clk_sys_i);
        #1;
        chk("t2_async", 32'hAF, 32'(periph_clk_stop_o));
        xfer(1'b1, spr_pkg::PRR_OFF, 32'h0);
        timer2_async_select_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk("gates_off", 32'h0, {23'h0, comparator_mux_deny_o, periph_clk_stop_o});
        xfer(1'b1, spr_pkg::SLEEP_OFF, 32'hFF);
        xfer(1'b0, spr_pkg::SLEEP_OFF, 32'h0);
        chk("sleep_rd", 32'h0F, rdv);
        xfer(1'b0, 12'h200, 32'h0);
        chk("unmapped", 32'h1, {31'h0, erv});
        xfer(1'b1, spr_pkg::SLEEP_OFF, 32'h0C);
        do_sleep(3'h6, 1'b0, 0, 1'b0);
        foreach (md[i]) begin
            xfer(1'b1, spr_pkg::SLEEP_OFF, {28'h0, md[i], 1'b1});
            do_sleep(md[i], 1'b1, (md[i] >= 3'h6) ? 6 : 8, 1'b0);
        end
        xfer(1'b1, spr_pkg::CORE_OFF, 32'h40);
        xfer(1'b0, spr_pkg::CORE_OFF, 32'h0);
        chk("bso_locked", 32'h0, rdv);
        xfer(1'b1, spr_pkg::SLEEP_OFF, 32'h05);
        @(posedge clk_sys_i);
        apb(1'b1, spr_pkg::CORE_OFF, 32'h60);
        apb(1'b1, spr_pkg::CORE_OFF, 32'h40);
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        do_sleep(3'h2, 1'b1, 8, 1'b1);
        xfer(1'b0, spr_pkg::CORE_OFF, 32'h0);
        chk("bso_clear", 32'h0, rdv);
        rst_case(4'hC, 3, 1'b1, 1'b1);
        rst_case(4'h0, 3, 1'b1, 1'b1);
        rst_case(4'h6, 1, 1'b1, 1'b1);
        rst_case(4'h5, 12, 1'b1, 1'b0);
        rst_case(4'h5, 2, 1'b0, 1'b0);
        reset_pin_disable_fuse_i <= 1'b1;
        wdt_system_mode_i        <= 1'b0;
        brownout_enable_fuse_i   <= 1'b0;
        rst_case(4'h0, 5, 1'b0, 1'b1);
        rst_case(4'h6, 1, 1'b0, 1'b1);
        rst_case(4'h5, 12, 1'b0, 1'b0);
        close_out();
    end
endmodule
